// [logic/tcs_pkg.sv]
// Constants for the tape unit command and status block
// Behaviour
// - Bit 0 starts transfer controller, not with 13
// - Bit 4 one selects unitary command format
// - Bit 1 connects selected interrupt, else disconnects
// - Bit 2 word interrupt, bit 3 record
// - Write record, check character, then gap
// - Cyclic check four chars before longitudinal
// - End-of-file: erase then write mark
// - Read record passes words until gap
// - Dropped request sets overflow; test bit 2
// - Forward space one record into gap
// - Forward space past next file mark
// - Backspace record or file, data intact
// - Write ops leave write status, others read
// - Accepted motion command clears all status
// - Tests report on currently set up transport
// - Skip only if every queried condition go
// - Test bit 0 skips when not busy
// - Bits 1,3,5: no file mark, load point, parity
// - Test bit 4 skips on record interrupt
// - Test bit 8 skips while rewinding
// - Cyclic check regenerated on read, bit 9
// - Without controller, stalled output ends record
// - Record interrupt on end of each written or read record
// - Word interrupt per buffer ready, write from second
`default_nettype none
package tcs_pkg;
  // ---------------------------------------------------------------
  // Command word bits
  // ---------------------------------------------------------------
  localparam int CMD_XFER_INIT = 0;
  localparam int CMD_INT_ON = 1;
  localparam int CMD_SEL_WORD = 2;
  localparam int CMD_SEL_EOR = 3;
  localparam int CMD_FORMAT = 4;
  localparam int CMD_WRITE = 5;
  localparam int CMD_WEOF = 6;
  localparam int CMD_READ = 7;
  localparam int CMD_FSR = 8;
  localparam int CMD_FSF = 9;
  localparam int CMD_BSR = 10;
  localparam int CMD_BSF = 11;
  localparam int CMD_ADDR_IN = 13;
  // ---------------------------------------------------------------
  // Test word bits
  // ---------------------------------------------------------------
  localparam int TST_NOT_BUSY = 0;
  localparam int TST_NO_EOF = 1;
  localparam int TST_NO_OVF = 2;
  localparam int TST_LOAD_PT = 3;
  localparam int TST_EOR_INT = 4;
  localparam int TST_NO_PAR = 5;
  localparam int TST_RING = 6;
  localparam int TST_NO_EOT = 7;
  localparam int TST_REWIND = 8;
  localparam int TST_NO_CRC = 9;
  localparam int TST_USED = 10;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CHAR_TIME_NS = 5000;
  localparam int CHAR_CYC = CHAR_TIME_NS * CLK_MHZ / 1000;
  localparam int CRC_GAP_CHARS = 4;
  localparam int ERASE_MILS = 3500;
  localparam int MILS_PER_CHAR = 1;
  localparam int ERASE_CHARS = ERASE_MILS / MILS_PER_CHAR;
  localparam logic [7:0] LRC_RST = 8'h00;
  localparam logic [8:0] CRC_RST = 9'h000;
  // Phase of a motion
  typedef enum logic [3:0] {
    TCS_IDLE = 4'h0,
    TCS_WDATA = 4'h1,
    TCS_WPAD1 = 4'h2,
    TCS_WCRC = 4'h3,
    TCS_WPAD2 = 4'h4,
    TCS_WLRC = 4'h5,
    TCS_ERASE = 4'h6,
    TCS_WMARK = 4'h7,
    TCS_RDATA = 4'h8,
    TCS_SPACE = 4'h9,
    TCS_GAP = 4'ha
  } tcs_state_t;
endpackage : tcs_pkg
`default_nettype wire

// [logic/tcs_tape_unit.sv]
// Tape unit command decoder, motion sequencer and status tester
//
// Our own choices: the placing of the registers and strobed register access.
`default_nettype none
module tcs_tape_unit
  import tcs_pkg::*;
#(
  parameter int CHAR_CYCLES = CHAR_CYC,
  parameter int ERASE_COUNT = ERASE_CHARS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host command and test
  input wire logic cmd_word_instr,
  input wire logic test_skip_instr,
  input wire logic [15:0] host_word,
  output logic skip,
  // Host data words
  input wire logic word_output_instr,
  input wire logic word_input_instr,
  output logic [7:0] rd_word,
  output logic word_int,
  output logic eor_int,
  // Transfer controller
  output logic xfer_start,
  output logic xfer_addr_in,
  // Selected transport
  input wire logic tp_load_point,
  input wire logic tp_rewinding,
  input wire logic tp_ring_in,
  input wire logic tp_end_of_tape,
  input wire logic tp_gap,
  input wire logic tp_file_mark,
  input wire logic tp_char_valid,
  input wire logic [8:0] tp_rd_char,
  input wire logic tp_parity_err,
  input wire logic tp_nine_track,
  output logic [8:0] tp_wr_char,
  output logic tp_wr_strobe,
  output logic tp_erase,
  output logic tp_write_status,
  output logic tp_fwd,
  output logic tp_rev
);
  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  tcs_state_t state_q, state_d;
  logic [7:0] data_q;
  logic data_full_q;
  logic [15:0] tmr_q;
  logic [2:0] pad_q;
  logic [7:0] lrc_q;
  logic [8:0] crc_q;
  logic word_en_q, eor_en_q, eor_hit_q, first_q;
  logic eof_q, ovf_q, par_q, crc_err_q, wr_st_q;
  logic space_file_q, space_rev_q;
  logic busy, fmt1, motion_go;
  logic [6:0] mot;
  logic tick;
  logic [8:0] crc_next;
  logic [8:0] crc_hist1_q, crc_hist2_q, chr_hist1_q, chr_hist2_q;
  logic [15:0] erase_q;
  logic rec_seen_q, rec_end;
  // Format bit picks unitary decoding; unused bits never read
  assign fmt1 = cmd_word_instr && host_word[CMD_FORMAT];
  assign mot = host_word[CMD_BSF:CMD_WRITE];
  assign busy = state_q != TCS_IDLE;
  // Only one motion bit is expected from the host
  assign motion_go = fmt1 && !busy && (mot != 7'h00);
  assign tick = tmr_q == 16'h0000;
  assign rec_end = rec_seen_q && tp_gap;
  // Controller start is refused when address input also requested
  assign xfer_start = fmt1 && host_word[CMD_XFER_INIT]
    && !host_word[CMD_ADDR_IN];
  assign xfer_addr_in = fmt1 && host_word[CMD_ADDR_IN]
    && !host_word[CMD_XFER_INIT];
  // ---------------------------------------------------------------
  // Interrupt connection
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      word_en_q <= 1'b0;
      eor_en_q <= 1'b0;
    end else if (fmt1) begin
      // Bit 1 matters only when a selector bit is set
      if (host_word[CMD_SEL_WORD]) begin
        word_en_q <= host_word[CMD_INT_ON];
      end
      if (host_word[CMD_SEL_EOR]) begin
        eor_en_q <= host_word[CMD_INT_ON];
      end
    end
  end
  // ---------------------------------------------------------------
  // Check characters
  // ---------------------------------------------------------------
  // Simple shift-xor cyclic code over nine bits
  assign crc_next = {crc_q[7:0], crc_q[8]}
    ^ (state_q == TCS_WDATA ? {1'b0, data_q} : tp_rd_char);
  // ---------------------------------------------------------------
  // Motion sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TCS_IDLE: begin
        if (motion_go) begin
          if (mot[0]) state_d = TCS_WDATA;
          else if (mot[1]) state_d = TCS_ERASE;
          else if (mot[2]) state_d = TCS_RDATA;
          else state_d = TCS_SPACE;
        end
      end
      // Host stalling one char time ends the record
      TCS_WDATA: if (tick && !data_full_q) begin
        state_d = tp_nine_track ? TCS_WPAD1 : TCS_WLRC;
      end
      TCS_WPAD1: if (tick && pad_q == 3'd0) state_d = TCS_WCRC;
      TCS_WCRC: if (tick) state_d = TCS_WPAD2;
      TCS_WPAD2: if (tick && pad_q == 3'd0) state_d = TCS_WLRC;
      TCS_WLRC: if (tick) state_d = TCS_GAP;
      TCS_ERASE: if (tick && erase_q == 16'h0000) state_d = TCS_WMARK;
      TCS_WMARK: if (tick) state_d = TCS_GAP;
      // Starting gap is skipped; the next one ends the motion
      TCS_RDATA: if (rec_end) state_d = TCS_GAP;
      TCS_SPACE: if (rec_end && (!space_file_q || tp_file_mark)) begin
        state_d = TCS_GAP;
      end
      TCS_GAP: if (tick) state_d = TCS_IDLE;
      default: state_d = TCS_IDLE;
    endcase
  end
  // State and char timer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= TCS_IDLE;
      tmr_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      tmr_q <= (tick || state_d != state_q) ?
        16'(CHAR_CYCLES - 1) : tmr_q - 16'h0001;
    end
  end
  // Pad counter: four char times either side of cyclic char
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pad_q <= 3'd0;
    end else if (state_d != state_q) begin
      pad_q <= 3'(CRC_GAP_CHARS - 1);
    end else if (tick && pad_q != 3'd0) begin
      pad_q <= pad_q - 3'd1;
    end
  end
  // Erase length counted in char times
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      erase_q <= 16'h0000;
    end else if (motion_go) begin
      erase_q <= 16'(ERASE_COUNT - 1);
    end else if (state_q == TCS_ERASE && tick && erase_q != 16'h0000) begin
      erase_q <= erase_q - 16'h0001;
    end
  end
  // Heads start mid-gap: a record must pass before a gap ends it
  always_ff @(posedge sys_clk) begin
    if (!rst_b || motion_go) begin
      rec_seen_q <= 1'b0;
    end else if (busy && !tp_gap) begin
      rec_seen_q <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // Data buffer and word interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_q <= 8'h00;
      data_full_q <= 1'b0;
      first_q <= 1'b0;
      rd_word <= 8'h00;
      lrc_q <= LRC_RST;
      crc_q <= CRC_RST;
      crc_hist1_q <= CRC_RST;
      crc_hist2_q <= CRC_RST;
      chr_hist1_q <= CRC_RST;
      chr_hist2_q <= CRC_RST;
    end else if (motion_go) begin
      data_full_q <= 1'b0;
      first_q <= 1'b1;
      lrc_q <= LRC_RST;
      crc_q <= CRC_RST;
      crc_hist1_q <= CRC_RST;
      crc_hist2_q <= CRC_RST;
      chr_hist1_q <= CRC_RST;
      chr_hist2_q <= CRC_RST;
      data_q <= 8'h00;
    end else begin
      if (word_output_instr && state_q == TCS_WDATA) begin
        data_q <= host_word[7:0];
        data_full_q <= 1'b1;
      end else if (state_q == TCS_WDATA && tick && data_full_q) begin
        data_full_q <= 1'b0;
        first_q <= 1'b0;
        lrc_q <= lrc_q ^ data_q;
        crc_q <= crc_next;
      end
      // Read path: each char goes straight to the host
      if (state_q == TCS_RDATA && tp_char_valid) begin
        rd_word <= tp_rd_char[7:0];
        data_full_q <= 1'b1;
        crc_q <= crc_next;
        // History: the cyclic char sits second from last in a record
        crc_hist1_q <= crc_q;
        crc_hist2_q <= crc_hist1_q;
        chr_hist1_q <= tp_rd_char;
        chr_hist2_q <= chr_hist1_q;
      end else if (state_q == TCS_RDATA && word_input_instr) begin
        data_full_q <= 1'b0;
      end
    end
  end
  // Write: ready from second word; read: every loaded word
  assign word_int = word_en_q && (
    (state_q == TCS_WDATA && !data_full_q && !first_q)
    || (state_q == TCS_RDATA && data_full_q));
  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      eof_q <= 1'b0;
      ovf_q <= 1'b0;
      par_q <= 1'b0;
      crc_err_q <= 1'b0;
      eor_hit_q <= 1'b0;
      wr_st_q <= 1'b0;
      space_file_q <= 1'b0;
      space_rev_q <= 1'b0;
    end else if (motion_go) begin
      // New motion wipes all status
      eof_q <= 1'b0;
      ovf_q <= 1'b0;
      par_q <= 1'b0;
      crc_err_q <= 1'b0;
      eor_hit_q <= 1'b0;
      wr_st_q <= mot[0] | mot[1];
      space_file_q <= mot[4] | mot[6];
      space_rev_q <= mot[5] | mot[6];
    end else begin
      // Host not taking the previous word before the next char
      if (state_q == TCS_RDATA && tp_char_valid && data_full_q) begin
        ovf_q <= 1'b1;
      end
      if (busy && !wr_st_q && tp_parity_err) par_q <= 1'b1;
      if (busy && !wr_st_q && tp_file_mark) eof_q <= 1'b1;
      // Recorded cyclic char compared on read
      if (state_q == TCS_RDATA && rec_end && tp_nine_track
        && crc_hist2_q != chr_hist2_q) begin
        crc_err_q <= 1'b1;
      end
      if (state_d == TCS_GAP && state_q != TCS_GAP
        && (state_q == TCS_WLRC || state_q == TCS_RDATA)) begin
        eor_hit_q <= eor_en_q;
      end
    end
  end
  assign eor_int = eor_hit_q;
  // ---------------------------------------------------------------
  // Transport drive
  // ---------------------------------------------------------------
  assign tp_write_status = wr_st_q;
  assign tp_erase = state_q == TCS_ERASE;
  // Direction held through the closing gap as well
  assign tp_rev = busy && space_rev_q;
  assign tp_fwd = busy && !tp_rev;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tp_wr_char <= 9'h000;
      tp_wr_strobe <= 1'b0;
    end else begin
      tp_wr_strobe <= tick && ((state_q == TCS_WDATA && data_full_q)
        || state_q == TCS_WCRC || state_q == TCS_WLRC
        || state_q == TCS_WMARK);
      unique case (state_q)
        TCS_WCRC: tp_wr_char <= crc_q;
        TCS_WLRC: tp_wr_char <= {1'b0, lrc_q};
        TCS_WMARK: tp_wr_char <= 9'h013;
        default: tp_wr_char <= {1'b0, data_q};
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Test skip
  // ---------------------------------------------------------------
  logic [TST_USED-1:0] go;
  // Live transport inputs reflect the transport set up now
  assign go[TST_NOT_BUSY] = !busy;
  assign go[TST_NO_EOF] = !eof_q;
  assign go[TST_NO_OVF] = !ovf_q;
  assign go[TST_LOAD_PT] = tp_load_point;
  assign go[TST_EOR_INT] = eor_hit_q;
  assign go[TST_NO_PAR] = !par_q;
  assign go[TST_RING] = tp_ring_in;
  assign go[TST_NO_EOT] = !tp_end_of_tape;
  assign go[TST_REWIND] = tp_rewinding;
  assign go[TST_NO_CRC] = !crc_err_q;
  // Every queried bit must be go; bits above ignored
  assign skip = test_skip_instr
    && ((host_word[TST_USED-1:0] & ~go) == '0);
endmodule : tcs_tape_unit
`default_nettype wire

// [tb/tcs_tape_unit_asserts.sv]
// Port checks for the tape unit command and status block
`default_nettype none
module tcs_chk
  import tcs_pkg::*;
#(
  parameter int CHAR_CYCLES = CHAR_CYC,
  parameter int ERASE_COUNT = ERASE_CHARS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_word_instr,
  input wire logic test_skip_instr,
  input wire logic [15:0] host_word,
  input wire logic skip,
  input wire logic eor_int,
  input wire logic xfer_start,
  input wire logic tp_load_point,
  input wire logic tp_rewinding,
  input wire logic tp_wr_strobe,
  input wire logic tp_erase,
  input wire logic tp_write_status,
  input wire logic tp_fwd,
  input wire logic tp_rev
);
  // ---------------------------------------------------------------
  // Relations
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Test word present this cycle
  wire logic tst = test_skip_instr;
  xfer_go_a: assert property (
    xfer_start |-> cmd_word_instr && host_word[0] && !host_word[13])
    else $error("bad transfer start");
  busy_skip_a: assert property (
    tst && host_word[0] && (tp_fwd || tp_rev) |-> !skip)
    else $error("skip while moving");
  load_skip_a: assert property (
    tst && host_word[3] && !tp_load_point |-> !skip)
    else $error("skip off load point");
  rewind_skip_a: assert property (
    tst && host_word[8] && !tp_rewinding |-> !skip)
    else $error("skip while not rewinding");
  write_stat_a: assert property (
    tp_wr_strobe || tp_erase |-> tp_write_status)
    else $error("writing in read status");
  rev_safe_a: assert property (
    tp_rev |-> !tp_fwd && !tp_wr_strobe && !tp_erase)
    else $error("reverse motion alters tape");
  char_gap_a: assert property (
    $rose(tp_wr_strobe) |=> !tp_wr_strobe [*3])
    else $error("characters too close");
  eor_hold_a: assert property (
    eor_int && !cmd_word_instr |=> eor_int)
    else $error("record interrupt lost");
endmodule : tcs_chk

bind tcs_tape_unit tcs_chk #(
  .CHAR_CYCLES(CHAR_CYCLES), .ERASE_COUNT(ERASE_COUNT)
) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .cmd_word_instr(cmd_word_instr),
  .test_skip_instr(test_skip_instr), .host_word(host_word), .skip(skip),
  .eor_int(eor_int), .xfer_start(xfer_start),
  .tp_load_point(tp_load_point), .tp_rewinding(tp_rewinding),
  .tp_wr_strobe(tp_wr_strobe), .tp_erase(tp_erase),
  .tp_write_status(tp_write_status), .tp_fwd(tp_fwd), .tp_rev(tp_rev)
);
`default_nettype wire

// [tb/tcs_transport_model.sv]
// Behavioural transport: one short record per motion in read status
`default_nettype none
module tcs_transport_model
  import tcs_pkg::*;
#(
  parameter int CHAR_CYCLES = 4,
  parameter int REC_CHARS = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tp_fwd,
  input wire logic tp_rev,
  input wire logic tp_write_status,
  output logic tp_gap,
  output logic tp_char_valid,
  output logic [8:0] tp_rd_char
);
  // ---------------------------------------------------------------
  // Record stream
  // ---------------------------------------------------------------
  wire logic run = tp_fwd | tp_rev;
  int cyc_q;
  int pos_q;
  // Stopped heads sit in a gap; the read lines toggle between
  // characters so a stale value never passes for data
  always_ff @(posedge sys_clk) begin
    tp_char_valid <= 1'b0;
    tp_rd_char <= rst_b ? ~tp_rd_char : 9'h000;
    cyc_q <= (cyc_q + 1) % CHAR_CYCLES;
    if (!rst_b || !run) begin
      cyc_q <= 0;
      pos_q <= 0;
      tp_gap <= 1'b1;
    end else begin
      tp_gap <= (pos_q == REC_CHARS);
      if (cyc_q == CHAR_CYCLES - 1 && pos_q < REC_CHARS &&
          !tp_write_status) begin
        tp_char_valid <= 1'b1;
        tp_rd_char <= 9'h0a0 + 9'(pos_q);
        pos_q <= pos_q + 1;
      end
    end
  end
endmodule : tcs_transport_model
`default_nettype wire

// [tb/tb_tcs_tape_unit.sv]
// Self-checking bench for the tape unit command and status block
`default_nettype none
module tb_tcs_tape_unit
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic sys_clk, rst_b, cmd_word_instr, test_skip_instr, skip, skip_s;
  logic word_output_instr, word_input_instr, word_int, eor_int, xs;
  logic tp_load_point, tp_rewinding, tp_file_mark, tp_nine_track;
  logic tp_wr_strobe, tp_erase, tp_write_status, tp_fwd, tp_rev;
  logic tp_gap, tp_char_valid, xfer_start, xfer_addr_in, xa;
  logic tp_ring_in, tp_end_of_tape, tp_parity_err;
  logic [15:0] host_word;
  logic [7:0] rd_word;
  logic [8:0] tp_rd_char, tp_wr_char;
  logic [8:0] wlog [$];
  int err_total, compares, cycles, erased;
  always #2.5 sys_clk = ~sys_clk;
  tcs_tape_unit #(.CHAR_CYCLES(4), .ERASE_COUNT(8)) dut_u (.sys_clk, .rst_b,
    .cmd_word_instr, .test_skip_instr, .host_word, .skip, .word_output_instr,
    .word_input_instr, .rd_word, .word_int, .eor_int, .xfer_start,
    .xfer_addr_in, .tp_load_point, .tp_rewinding, .tp_ring_in,
    .tp_end_of_tape, .tp_gap, .tp_file_mark, .tp_char_valid,
    .tp_rd_char, .tp_parity_err, .tp_nine_track, .tp_wr_char,
    .tp_wr_strobe, .tp_erase, .tp_write_status, .tp_fwd, .tp_rev);
  tcs_transport_model #(.CHAR_CYCLES(4), .REC_CHARS(3)) far_u (.sys_clk,
    .rst_b, .tp_fwd, .tp_rev, .tp_write_status, .tp_gap, .tp_char_valid,
    .tp_rd_char);
  // Written characters logged, hang cut short at a fixed ceiling
  always @(negedge sys_clk) begin
    if (tp_wr_strobe === 1'b1) wlog.push_back(tp_wr_char);
    if (tp_erase === 1'b1) erased++;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // One command or test word; outputs sampled mid-cycle
  task automatic issue(input logic [15:0] w, input logic tst);
    @(posedge sys_clk);
    host_word <= w;
    if (tst) test_skip_instr <= 1'b1;
    else cmd_word_instr <= 1'b1;
    @(negedge sys_clk);
    {skip_s, xs, xa} = {skip, xfer_start, xfer_addr_in};
    @(posedge sys_clk);
    cmd_word_instr <= 1'b0;
    test_skip_instr <= 1'b0;
  endtask : issue
  task automatic sk(input logic [15:0] w, input logic e);
    issue(w, 1'b1);
    check(skip_s, e);
  endtask : sk
  // Polls the not-busy test, bounded
  task automatic wait_idle;
    skip_s = 1'b0;
    repeat (300) if (skip_s !== 1'b1) issue(16'h0001, 1'b1);
    check(skip_s, 1'b1);
  endtask : wait_idle
  task automatic wait_word;
    @(negedge sys_clk);
    repeat (100) if (word_int !== 1'b1) @(negedge sys_clk);
    check(word_int, 1'b1);
  endtask : wait_word
  task automatic put(input logic [15:0] w, input logic wr);
    @(posedge sys_clk);
    host_word <= w;
    word_output_instr <= wr;
    word_input_instr <= !wr;
    @(posedge sys_clk);
    word_output_instr <= 1'b0;
    word_input_instr <= 1'b0;
  endtask : put
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_clk, rst_b, cmd_word_instr, test_skip_instr} = '0;
    {word_output_instr, word_input_instr, tp_load_point, skip_s} = '0;
    {tp_rewinding, tp_file_mark, tp_nine_track, host_word} = '0;
    {err_total, compares, cycles, erased} = '0;
    {tp_ring_in, tp_end_of_tape, tp_parity_err} = 3'h4;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    issue(16'hd011, 1'b0);
    check({xs, xa}, 2'h2);
    issue(16'h2011, 1'b0);
    check({xs, xa}, 2'h0);
    issue(16'h2010, 1'b0);
    check({xs, xa}, 2'h1);
    issue(16'h001e, 1'b0);
    tp_load_point <= 1'b1;
    sk(16'hfc2f, 1'b1);
    sk(16'h0010, 1'b0);
    sk(16'h0108, 1'b0);
    tp_rewinding <= 1'b1;
    sk(16'h0100, 1'b1);
    tp_load_point <= 1'b0;
    sk(16'h0108, 1'b0);
    sk(16'h00c0, 1'b1);
    {tp_ring_in, tp_end_of_tape} <= 2'h1;
    sk(16'h0040, 1'b0);
    sk(16'h0080, 1'b0);
    issue(16'h0020, 1'b0);
    repeat (2) @(negedge sys_clk);
    check(tp_fwd, 1'b0);
    $display("status tests done");
    // Write a three word record on both track counts
    for (int nt = 1; nt >= 0; nt--) begin
      tp_nine_track <= nt[0];
      wlog.delete();
      issue(16'h0030, 1'b0);
      put(16'h0055, 1'b1);
      for (int i = 1; i < 3; i++) begin
        wait_word();
        put(16'h0055 + 16'(i), 1'b1);
      end
      wait_idle();
      check(16'(wlog.size()), 16'(4 + nt));
      check({8'h00, wlog[1][7:0]}, 16'h0056);
      check({eor_int, tp_write_status}, 2'b11);
      sk(16'h0010, 1'b1);
    end
    $display("write tests done");
    tp_nine_track <= 1'b1;
    issue(16'h0090, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wait_word();
      check(rd_word, 8'ha0 + 8'(i));
      put(16'h0000, 1'b0);
    end
    wait_idle();
    check(tp_write_status, 1'b0);
    sk(16'h0014, 1'b1);
    sk(16'h0200, 1'b0);
    tp_nine_track <= 1'b0;
    // Unread record with its interrupt off; a write while busy
    issue(16'h0018, 1'b0);
    issue(16'h0090, 1'b0);
    issue(16'h0030, 1'b0);
    wait_idle();
    check({eor_int, tp_write_status}, 2'b00);
    sk(16'h0004, 1'b0);
    sk(16'h0200, 1'b1);
    $display("read tests done");
    for (int b = 8; b < 12; b++) begin
      tp_file_mark <= b[0];
      tp_parity_err <= (b == 10);
      issue(16'h0010 | (16'h0001 << b), 1'b0);
      repeat (2) @(negedge sys_clk);
      check({tp_fwd, tp_rev}, b < 10 ? 2'b10 : 2'b01);
      wait_idle();
      sk(16'h0026, !b[0] && b != 10);
    end
    check(16'(wlog.size()), 16'h0004);
    $display("spacing tests done");
    {tp_file_mark, tp_parity_err} <= 2'h0;
    issue(16'h0050, 1'b0);
    wait_idle();
    check(16'(erased), 16'h0020);
    check({tp_write_status, wlog[$][7:0]}, 9'h113);
    sk(16'h0020, 1'b1);
    $display("file mark test done");
    finish_test();
  end
endmodule : tb_tcs_tape_unit
`default_nettype wire
